/* File: hw/sbspc_map.svh */
`ifndef SBSPC_MAP_SVH
`define SBSPC_MAP_SVH

// Default geometry: 256K words of 36 bits in four byte lanes
`define SBSPC_ADDR_W_DEF 18
`define SBSPC_DATA_W_DEF 36
`define SBSPC_LANES_DEF 4

// Burst counter width, reset and step
`define SBSPC_BURST_W 2
`define SBSPC_CNT_RST 2'h0
`define SBSPC_CNT_STEP 2'h1

// Reset levels of the synchroniser stages
`define SBSPC_OE_SYNC_RST 1'h1
`define SBSPC_ORD_SYNC_RST 1'h1

// Reset levels of the access state
`define SBSPC_LANES_RST 1'h1
`define SBSPC_EMERGE_RST 1'h0

`endif

/* File: hw/sbspc_pkg.sv */
package sbspc_pkg;

    // Kind of access held between qualified edges
    typedef enum logic [1:0] {
        SBSPC_DESEL,
        SBSPC_READ,
        SBSPC_WRITE
    } sbspc_op_t;

endpackage

/* File: hw/sbspc_port.sv */
`timescale 1ns/1ps
`include "sbspc_map.svh"

// Functional notes
// - Address captured on rising clock edge
// - Low two address bits load burst counter
// - Byte lane strobes select written lanes
// - Write strobe sampled only on qualified edges
// - Advance high steps the burst counter
// - Advance low loads new address, new access
// - Edges ignored while clock qualifier high
// - Selected only when selects are low-high-low
// - Output drive low lets pins drive data
// - Pins off in write, emerge, deselect
// - Read data from preceding qualified edge address
// - Qualifier high freezes state, no deselect
// - Strap picks linear or interleaved order
module sbspc_port
    import sbspc_pkg::*;
#(
    parameter int ADDR_W = `SBSPC_ADDR_W_DEF, // Word address width
    parameter int DATA_W = `SBSPC_DATA_W_DEF, // Data width
    parameter int LANES = `SBSPC_LANES_DEF // Byte lanes
) (
    input wire logic core_clk, // Port clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic core_ce, // Clock enable, freezes all state when low
    input wire logic [ADDR_W-3:0] addr_upper, // Upper address bits
    input wire logic burst_low_bit, // Address bit 0
    input wire logic burst_high_bit, // Address bit 1
    input wire logic [LANES-1:0] byte_lane_write_n, // Byte lane write, active low
    input wire logic write_n, // Write strobe, active low
    input wire logic advance_or_load, // High advance, low load
    input wire logic clock_qualifier_n, // Clock qualifier, active low
    input wire logic select_one_n, // Select one, active low
    input wire logic select_two, // Select two, active high
    input wire logic select_three_n, // Select three, active low
    input wire logic output_drive_n, // Asynchronous output drive, active low
    input wire logic burst_order_sel, // Strap: low linear, high interleaved
    input wire logic [DATA_W-1:0] dq_in, // Data pins, input side
    output logic [DATA_W-1:0] dq_out, // Data pins, output side
    output logic dq_oe // Data pins drive enable, high drives
);

    localparam int LANE_W = DATA_W / LANES; // Bits per lane
    localparam int DEPTH = 2 ** ADDR_W; // Words in array

    // Refuse geometries the lane split or the address split cannot serve
    if ((DATA_W % LANES) != 0 || ADDR_W < 3 || LANES < 1) begin : g_bad_geom
        $error("sbspc_port: unusable geometry");
    end

    // All control state of the port
    typedef struct packed {
        logic oe_s1; // Output drive sync, stage one
        logic oe_s2; // Output drive sync, stage two
        logic ord_s1; // Burst order sync, stage one
        logic ord_s2; // Burst order sync, stage two
        sbspc_op_t op; // Current access kind
        logic emerge; // First access after deselect
        logic [ADDR_W-3:0] addr_hi; // Captured upper address
        logic [`SBSPC_BURST_W-1:0] start_lo; // Captured low address bits
        logic [`SBSPC_BURST_W-1:0] cnt; // Burst beat counter
        logic [LANES-1:0] lanes_n; // Lane strobes for pending write
        logic [DATA_W-1:0] rd_data; // Registered read data
    } sbspc_state_t;

    // Reset image of the state
    localparam sbspc_state_t ST_RST = '{
        oe_s1: `SBSPC_OE_SYNC_RST,
        oe_s2: `SBSPC_OE_SYNC_RST,
        ord_s1: `SBSPC_ORD_SYNC_RST,
        ord_s2: `SBSPC_ORD_SYNC_RST,
        op: SBSPC_DESEL,
        emerge: `SBSPC_EMERGE_RST,
        addr_hi: '0,
        start_lo: `SBSPC_CNT_RST,
        cnt: `SBSPC_CNT_RST,
        lanes_n: {LANES{`SBSPC_LANES_RST}},
        rd_data: '0
    };

    sbspc_state_t st_q; // Registered state
    sbspc_state_t st_d; // Next state
    logic [DATA_W-1:0] mem [DEPTH]; // Storage array
    logic qual; // Qualified edge this cycle
    logic sel; // Selects sampled as selected
    logic wr_now; // Write data phase at this edge
    logic [ADDR_W-1:0] cur_addr; // Address of current beat
    logic [ADDR_W-1:0] nxt_addr; // Address of next beat
    logic [DATA_W-1:0] rd_word; // Array word for next beat

    // Low address bits of a beat in linear or interleaved order
    function automatic logic [`SBSPC_BURST_W-1:0] burst_lo(
        input logic [`SBSPC_BURST_W-1:0] start,
        input logic [`SBSPC_BURST_W-1:0] cnt,
        input logic interleave
    );
        // Two-bit arithmetic wraps inside the group of four
        burst_lo = interleave ? (start ^ cnt) : (start + cnt);
    endfunction

    // Merge new lanes into an old word, strobes active low
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0] lanes_n
    );
        lane_merge = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!lanes_n[i]) begin
                lane_merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
    endfunction

    // Edge qualification and decode of the present inputs
    always_comb begin
        qual = core_ce && !clock_qualifier_n;
        sel = !select_one_n && select_two && !select_three_n;
        wr_now = qual && (st_q.op == SBSPC_WRITE);
        cur_addr = {st_q.addr_hi, burst_lo(st_q.start_lo, st_q.cnt, st_q.ord_s2)};
    end

    // Next state of the access sequencer
    always_comb begin
        st_d = st_q;
        // Output drive and strap pass two flops
        st_d.oe_s1 = output_drive_n;
        st_d.oe_s2 = st_q.oe_s1;
        st_d.ord_s1 = burst_order_sel;
        st_d.ord_s2 = st_q.ord_s1;
        if (qual) begin
            if (!advance_or_load) begin
                // Load: new address and new access
                if (sel) begin
                    st_d.addr_hi = addr_upper;
                    st_d.start_lo = {burst_high_bit, burst_low_bit};
                    st_d.cnt = `SBSPC_CNT_RST;
                    st_d.op = write_n ? SBSPC_READ : SBSPC_WRITE;
                    st_d.lanes_n = byte_lane_write_n;
                    st_d.emerge = (st_q.op == SBSPC_DESEL);
                end else begin
                    // Deselect ends any burst
                    st_d.op = SBSPC_DESEL;
                    st_d.emerge = `SBSPC_EMERGE_RST;
                end
            end else if (st_q.op != SBSPC_DESEL) begin
                // Advance: next beat of the same burst
                st_d.cnt = st_q.cnt + `SBSPC_CNT_STEP;
                st_d.lanes_n = byte_lane_write_n;
                st_d.emerge = `SBSPC_EMERGE_RST;
            end else begin
                // Advance while deselected stays deselected
                st_d.op = SBSPC_DESEL;
            end
        end
        nxt_addr = {st_d.addr_hi, burst_lo(st_d.start_lo, st_d.cnt, st_q.ord_s2)};
        rd_word = mem[nxt_addr];
        // Forward a write landing on the word being read
        if (wr_now && (nxt_addr == cur_addr)) begin
            rd_word = lane_merge(rd_word, dq_in, st_q.lanes_n);
        end
        if (qual && (st_d.op == SBSPC_READ)) begin
            st_d.rd_data = rd_word;
        end
    end

    // State register, frozen by clock enable; qualifier holds all but the synchronisers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= ST_RST;
        end else if (core_ce) begin
            st_q <= st_d;
        end
    end

    // Array write in the data phase of a write beat
    always_ff @(posedge core_clk) begin
        if (wr_now) begin
            mem[cur_addr] <= lane_merge(mem[cur_addr], dq_in, st_q.lanes_n);
        end
    end

    // Pin drive: read phase, not emerging, output drive low
    always_comb begin
        dq_out = st_q.rd_data;
        dq_oe = !st_q.oe_s2 && (st_q.op == SBSPC_READ) && !st_q.emerge;
    end

    // Checks on the sequencer
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    AST_ADDR_CAPTURE: assert property (
        qual && !advance_or_load && sel |=> st_q.addr_hi == $past(addr_upper))
        else $error("upper address not captured on load");

    AST_BURST_LOAD: assert property (
        qual && !advance_or_load && sel
        |=> st_q.cnt == `SBSPC_CNT_RST
            && st_q.start_lo == $past({burst_high_bit, burst_low_bit}))
        else $error("burst counter not loaded from low address bits");

    AST_LANES_TAKEN: assert property (
        qual && !advance_or_load && sel && !write_n
        |=> st_q.lanes_n == $past(byte_lane_write_n))
        else $error("byte lane strobes not captured for write");

    AST_WRITE_KIND: assert property (
        qual && !advance_or_load && sel
        |=> (st_q.op == SBSPC_WRITE) == !$past(write_n))
        else $error("access kind does not follow write strobe");

    AST_ADVANCE_STEP: assert property (
        qual && advance_or_load && st_q.op != SBSPC_DESEL
        |=> st_q.cnt == $past(st_q.cnt) + `SBSPC_CNT_STEP && $stable(st_q.op))
        else $error("burst counter did not advance");

    AST_LOAD_DESEL: assert property (
        qual && !advance_or_load && !sel |=> st_q.op == SBSPC_DESEL)
        else $error("load without select did not deselect");

    AST_FREEZE: assert property (
        core_ce && clock_qualifier_n
        |=> $stable(st_q.op) && $stable(st_q.cnt) && $stable(st_q.rd_data))
        else $error("state changed on an unqualified edge");

    AST_DRIVE_OFF: assert property (
        (core_ce && output_drive_n) ##1 core_ce |=> !dq_oe)
        else $error("pins driven with output drive high");

    AST_EMERGE_MASK: assert property (
        qual && !advance_or_load && sel && write_n && st_q.op == SBSPC_DESEL
        |=> !dq_oe)
        else $error("pins driven in first clock after deselect");

    AST_WRITE_MASK: assert property (
        st_q.op != SBSPC_READ |-> !dq_oe)
        else $error("pins driven outside a read");

    AST_READ_DATA: assert property (
        $past(qual) && !$past(st_q.op == SBSPC_WRITE) && st_q.op == SBSPC_READ
        |-> st_q.rd_data == mem[cur_addr])
        else $error("read data not from addressed word");

    AST_BURST_WRAP: assert property (
        qual && advance_or_load && st_q.op != SBSPC_DESEL
        |=> $stable(st_q.addr_hi) && $stable(st_q.start_lo))
        else $error("burst left its aligned group");

    // Clock enable low holds every state bit, synchronisers too
    AST_CE_HOLD: assert property (
        !core_ce |=> $stable(st_q))
        else $error("state changed with clock enable low");

    // Advance while deselected must not start an access
    AST_DESEL_ADVANCE: assert property (
        qual && advance_or_load && st_q.op == SBSPC_DESEL
        |=> st_q.op == SBSPC_DESEL)
        else $error("advance while deselected started an access");

    // First selected load after deselect raises the emerge mask
    AST_EMERGE_SET: assert property (
        qual && !advance_or_load && sel && st_q.op == SBSPC_DESEL
        |=> st_q.emerge)
        else $error("emerge mask not raised after deselect");

    // Any advance of a live burst ends the emerge mask
    AST_EMERGE_CLEAR: assert property (
        qual && advance_or_load && st_q.op != SBSPC_DESEL
        |=> !st_q.emerge)
        else $error("emerge mask held past first beat");

    // Linear order steps the low bits by one and wraps in four
    AST_ORDER_LINEAR: assert property (
        qual && advance_or_load && st_q.op != SBSPC_DESEL && !st_q.ord_s2
        |=> $changed(st_q.ord_s2)
            || cur_addr[`SBSPC_BURST_W-1:0]
               == $past(cur_addr[`SBSPC_BURST_W-1:0]) + `SBSPC_CNT_STEP)
        else $error("linear burst did not step by one");

    COV_READ_BURST: cover property (
        qual && !advance_or_load && sel && write_n
        ##1 (qual && advance_or_load) [*3]);

    COV_WRITE_READ: cover property (
        qual && !advance_or_load && sel && !write_n
        ##1 qual && !advance_or_load && sel && write_n);

    COV_FREEZE: cover property (
        st_q.op == SBSPC_READ ##0 (core_ce && clock_qualifier_n) [*2]);

    // Read held across a clock enable stall
    COV_CE_STALL: cover property (
        st_q.op == SBSPC_READ ##1 !core_ce [*2]);

    // Interleaved advance of a read burst
    COV_INTERLEAVE: cover property (
        st_q.ord_s2 && qual && advance_or_load && st_q.op == SBSPC_READ);

endmodule

/* File: sim/sbspc_ctl_model.sv */
`timescale 1ns/1ps
// Controller driving the port
module sbspc_ctl_model #(
    parameter int AW = 4, // Address width
    parameter int DW = 8, // Data width
    parameter int LN = 2 // Lanes
) (
    input wire logic core_clk, // Clock
    output logic [AW-3:0] addr_upper, // Upper address
    output logic burst_low_bit, // Bit 0
    output logic burst_high_bit, // Bit 1
    output logic [LN-1:0] byte_lane_write_n, // Lanes
    output logic write_n, // Write strobe
    output logic advance_or_load, // Advance or load
    output logic clock_qualifier_n, // Qualifier
    output logic select_one_n, // Select one
    output logic select_two, // Select two
    output logic select_three_n, // Select three
    output logic [DW-1:0] dq_in // Write data
);
    // Idle deselected from time zero
    initial begin
        {addr_upper, burst_high_bit, burst_low_bit} = '0;
        {write_n, advance_or_load, clock_qualifier_n} = 3'h4;
        {select_one_n, select_two, select_three_n} = 3'h7;
        byte_lane_write_n = '1;
        dq_in = '0;
    end
    // One qualified beat after some frozen edges
    task automatic beat(input logic adv, input logic wr, input logic [AW-1:0] a,
        input logic [LN-1:0] ln, input logic [DW-1:0] d, input logic [2:0] sel,
        input int stall);
        repeat (stall) begin
            {clock_qualifier_n, write_n} = 2'h2;
            byte_lane_write_n = '0;
            @(posedge core_clk);
            #1;
        end
        clock_qualifier_n = 1'h0;
        advance_or_load = adv;
        write_n = ~wr;
        {addr_upper, burst_high_bit, burst_low_bit} = a;
        byte_lane_write_n = ln;
        {select_one_n, select_two, select_three_n} = sel;
        dq_in = d;
        @(posedge core_clk);
        #1;
        dq_in = ~d; // Released data does not hold
    endtask
endmodule

/* File: sim/sbspc_port_tb.sv */
`timescale 1ns/1ps
module sbspc_port_tb;
    localparam int AW = 4;
    localparam int DW = 8;
    localparam int LN = 2;
    localparam logic [2:0] SEL = 3'h2; // Selected pattern
    logic core_clk = 1'h0; // Clock
    logic rstn = 1'h0; // Reset
    logic core_ce = 1'h1; // Clock enable
    logic output_drive_n = 1'h1; // Output drive
    logic burst_order_sel = 1'h0; // Strap, linear
    logic [AW-3:0] addr_upper; // Upper address
    logic burst_low_bit, burst_high_bit; // Burst bits
    logic [LN-1:0] lanes_n; // Lanes
    logic write_n, advance_or_load, clock_qualifier_n; // Controls
    logic select_one_n, select_two, select_three_n; // Selects
    logic [DW-1:0] dq_in, dq_out; // Data
    logic dq_oe; // Drive enable
    logic [DW-1:0] mem_x [0:15]; // Expected words
    int err_total = 0; // Mismatches
    int total_checks = 0; // Comparisons
    // Clock, 40 ns
    always #20 core_clk = ~core_clk;
    sbspc_ctl_model #(.AW(AW), .DW(DW), .LN(LN)) ctl (.core_clk(core_clk),
        .addr_upper(addr_upper), .burst_low_bit(burst_low_bit),
        .burst_high_bit(burst_high_bit), .byte_lane_write_n(lanes_n),
        .write_n(write_n), .advance_or_load(advance_or_load),
        .clock_qualifier_n(clock_qualifier_n), .select_one_n(select_one_n),
        .select_two(select_two), .select_three_n(select_three_n), .dq_in(dq_in));
    sbspc_port #(.ADDR_W(AW), .DATA_W(DW), .LANES(LN)) uut (.core_clk(core_clk),
        .rstn(rstn), .core_ce(core_ce), .addr_upper(addr_upper),
        .burst_low_bit(burst_low_bit), .burst_high_bit(burst_high_bit),
        .byte_lane_write_n(lanes_n), .write_n(write_n),
        .advance_or_load(advance_or_load), .clock_qualifier_n(clock_qualifier_n),
        .select_one_n(select_one_n), .select_two(select_two),
        .select_three_n(select_three_n), .output_drive_n(output_drive_n),
        .burst_order_sel(burst_order_sel), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe));
    // Compare and count
    task automatic chk(input string what, input logic [DW-1:0] exp,
        input logic [DW-1:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // Lane writes, forwarding, output drive
    task automatic t_lanes();
        ctl.beat(0, 1, 5, 2'h0, 8'h00, SEL, 0);
        chk("oe_wr", 1'h0, dq_oe);
        ctl.beat(0, 1, 5, 2'h2, 8'ha5, SEL, 0);
        ctl.beat(0, 0, 5, 2'h0, 8'h3c, SEL, 0);
        chk("rd_lane", 8'hac, dq_out);
        chk("oe_rd", 1'h1, dq_oe);
        output_drive_n = 1'h1;
        ctl.beat(0, 0, 5, 2'h3, 8'hff, SEL, 0);
        ctl.beat(0, 0, 5, 2'h3, 8'hff, SEL, 0);
        chk("rd_nowr", 8'hac, dq_out);
        chk("oe_off", 1'h0, dq_oe);
        output_drive_n = 1'h0;
        mem_x[5] = 8'hac;
    endtask
    // Linear burst write, interleaved burst read
    task automatic t_burst();
        ctl.beat(0, 1, 6, 2'h0, 8'h00, SEL, 0);
        for (int i = 0; i < 4; i++) begin
            ctl.beat(i < 3, 1, 6, 2'h0, 8'h10 + 8'(i), (i < 3) ? SEL : 3'h7, 0);
            mem_x[4 + (2 + i) % 4] = 8'h10 + 8'(i);
        end
        burst_order_sel = 1'h1;
        for (int i = 4; i < 8; i++) begin
            ctl.beat(0, 0, AW'(i), 2'h3, 8'h00, SEL, 0);
            chk("rd_lin", mem_x[i], dq_out);
        end
        ctl.beat(0, 0, 5, 2'h3, 8'h00, SEL, 0);
        for (int i = 1; i < 6; i++) begin
            ctl.beat(1, 0, 5, 2'h3, 8'h00, SEL, 0);
            chk("rd_int", mem_x[4 + (1 ^ (i % 4))], dq_out);
        end
    endtask
    // Frozen edges hold state, ignore writes
    task automatic t_freeze();
        ctl.beat(0, 0, 4, 2'h3, 8'h00, SEL, 0);
        ctl.beat(1, 0, 4, 2'h3, 8'h00, SEL, 3);
        chk("rd_frz", mem_x[5], dq_out);
        chk("oe_frz", 1'h1, dq_oe);
        ctl.beat(0, 0, 5, 2'h3, 8'h00, SEL, 0);
        chk("rd_frzw", mem_x[5], dq_out);
    endtask
    // Every select pattern, then emerge
    task automatic t_sel();
        for (int p = 0; p < 8; p++) begin
            ctl.beat(0, 0, 4, 2'h3, 8'h00, 3'(p), 0);
            chk("oe_sel", p == 2, dq_oe);
            ctl.beat(0, 0, 4, 2'h3, 8'h00, SEL, 0);
            chk("oe_emg", p == 2, dq_oe);
            chk("rd_sel", mem_x[4], dq_out);
        end
    endtask
    // Clock enable low ignores edges, even qualified ones
    task automatic t_ce();
        ctl.beat(0, 0, 4, 2'h3, 8'h00, SEL, 0);
        core_ce = 1'h0;
        ctl.beat(1, 0, 4, 2'h3, 8'h00, SEL, 0);
        ctl.beat(0, 0, 6, 2'h3, 8'h00, 3'h7, 0);
        chk("rd_ce", mem_x[4], dq_out);
        chk("oe_ce", 1'h1, dq_oe);
        core_ce = 1'h1;
        ctl.beat(1, 0, 4, 2'h3, 8'h00, SEL, 0);
        chk("rd_ceadv", mem_x[5], dq_out);
    endtask
    // Verdict
    task automatic results();
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        rstn = 1'h1;
        chk("oe_rst", 1'h0, dq_oe);
        output_drive_n = 1'h0;
        t_lanes();
        t_burst();
        t_freeze();
        t_sel();
        t_ce();
        results();
    end
    // Watchdog
    initial begin
        #100000;
        err_total++;
        results();
    end
endmodule
